// ---- logic/clock_divider_channels.sv ----
// Output channel clock dividers with their configuration registers on Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - High-speed divider B start level from bit 4.
// - High-speed divider B four-bit phase offset, reset zero.
// - Direct bit clear routes divider to pair B.
// - Direct set, source 10b: oscillator drives pair.
// - Direct set, source 00b: external clock drives pair.
// - Source 01b: direct bit has no effect.
// - Duty-correction-disable bit clear enables correction.
// - Channel A stage one low N+1 cycles.
// - Channel A stage one high M+1 cycles.
// - Channel A stage two has own counts.
// - Channel A phase offsets, stage two upper nibble.
// - Bit 5 bypasses channel A stage two.
// - Bit 4 bypasses channel A stage one.
// - Sync-ignore bit makes channel disregard sync.
// - Force level applies only with sync-ignore set.
// - Bits 1 and 0 set stage start levels.
// - Channel B stage one low/high counts plus one.
module clock_divider_channels (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Avalon-MM register slave.
  input  wire logic [10:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Distribution clock sources and chip-level sync.
  input  wire logic        osc_clk,
  input  wire logic        ext_clk,
  input  wire logic [1:0]  dist_src_sel,
  input  wire logic        sync_hold,
  // Divided clock outputs.
  output logic             hs_pair_b_out_first,
  output logic             hs_pair_b_out_second,
  output logic             ls_a_out,
  output logic             ls_b_stage1_out,
  // Duty-cycle correction enables.
  output logic             hs_b_dcc_on,
  output logic             ls_a_dcc_on
);

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  function automatic logic reg_hit(input logic [10:0] addr);
    return (addr[10:2] >= clkdiv_pkg::IDX_HS_DIV_B_CYCLES) &&
           (addr[10:2] <= clkdiv_pkg::IDX_LS_B_STAGE1_CYCLES);
  endfunction

  function automatic logic [3:0] reg_slot(input logic [10:0] addr);
    logic [8:0] diff;
    diff = addr[10:2] - clkdiv_pkg::IDX_HS_DIV_B_CYCLES;
    return diff[3:0];
  endfunction

  function automatic logic [7:0] reg_mask(input logic [3:0] slot);
    case (slot)
      clkdiv_pkg::SLOT_HS_RTE: return clkdiv_pkg::MASK_ROUTE;
      clkdiv_pkg::SLOT_A_CTL:  return clkdiv_pkg::MASK_LS_CTL;
      clkdiv_pkg::SLOT_A_DCC:  return clkdiv_pkg::MASK_DCC;
      default:                 return clkdiv_pkg::MASK_FULL;
    endcase
  endfunction

  function automatic clkdiv_pkg::div_s div_step(input clkdiv_pkg::div_s s,
                                                input logic [3:0]       lowc,
                                                input logic [3:0]       highc);
    clkdiv_pkg::div_s r;
    logic [3:0]       lim;
    r   = s;
    lim = s.lvl ? highc : lowc;
    if (s.hold != 4'h0) begin
      r.hold = s.hold - 4'h1;
    end else if (s.cnt == lim) begin
      r.lvl = ~s.lvl;
      r.cnt = 4'h0;
    end else begin
      r.cnt = s.cnt + 4'h1;
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------------
  clkdiv_pkg::bus_e bus_state;
  clkdiv_pkg::bus_e next_bus_state;
  logic [7:0]       cfg [0:8];
  logic [7:0]       next_cfg [0:8];
  logic [31:0]      next_readdata;
  logic             next_waitrequest;
  logic [3:0]       slot;

  always_comb begin
    slot             = reg_slot(avs_address);
    next_bus_state   = bus_state;
    next_waitrequest = 1'b1;
    next_readdata    = avs_readdata;
    next_cfg         = cfg;
    case (bus_state)
      clkdiv_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          next_bus_state   = clkdiv_pkg::BUS_ACK;
          next_waitrequest = 1'b0;
          next_readdata    = 32'h0000_0000;
          if (avs_read && reg_hit(avs_address)) begin
            next_readdata[7:0] = cfg[slot];
          end
        end
      end
      clkdiv_pkg::BUS_ACK: begin
        next_bus_state = clkdiv_pkg::BUS_IDLE;
        if (avs_write && avs_byteenable[0] && reg_hit(avs_address)) begin
          next_cfg[slot] = avs_writedata[7:0] & reg_mask(slot);
        end
      end
      default: begin
        next_bus_state = clkdiv_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_state       <= clkdiv_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      for (int i = 0; i < 9; i++) begin
        cfg[i] <= clkdiv_pkg::REG_RESET;
      end
    end else begin
      bus_state       <= next_bus_state;
      avs_waitrequest <= next_waitrequest;
      avs_readdata    <= next_readdata;
      cfg             <= next_cfg;
    end
  end

  // ---------------------------------------------------------------------------
  // Stage configuration
  // ---------------------------------------------------------------------------
  logic [3:0] st_low    [0:3];
  logic [3:0] st_high   [0:3];
  logic [3:0] st_phase  [0:3];
  logic       st_start  [0:3];
  logic       st_bypass [0:3];
  logic       st_nosync [0:3];
  logic       hs_force;
  logic       ls_force;
  logic       hs_direct;
  logic       dist_clk;

  always_comb begin
    st_low[clkdiv_pkg::STG_HS]    = cfg[clkdiv_pkg::SLOT_HS_CYC][7:4];
    st_high[clkdiv_pkg::STG_HS]   = cfg[clkdiv_pkg::SLOT_HS_CYC][3:0];
    st_phase[clkdiv_pkg::STG_HS]  = cfg[clkdiv_pkg::SLOT_HS_CTL][3:0];
    st_start[clkdiv_pkg::STG_HS]  = cfg[clkdiv_pkg::SLOT_HS_CTL][clkdiv_pkg::HS_START_BIT];
    st_bypass[clkdiv_pkg::STG_HS] = cfg[clkdiv_pkg::SLOT_HS_CTL][clkdiv_pkg::HS_BYPASS_BIT];
    st_nosync[clkdiv_pkg::STG_HS] = cfg[clkdiv_pkg::SLOT_HS_CTL][clkdiv_pkg::HS_NOSYNC_BIT];
    // Channel A stage one.
    st_low[clkdiv_pkg::STG_A1]    = cfg[clkdiv_pkg::SLOT_A1_CYC][7:4];
    st_high[clkdiv_pkg::STG_A1]   = cfg[clkdiv_pkg::SLOT_A1_CYC][3:0];
    st_phase[clkdiv_pkg::STG_A1]  = cfg[clkdiv_pkg::SLOT_A_PHS][3:0];
    st_start[clkdiv_pkg::STG_A1]  = cfg[clkdiv_pkg::SLOT_A_CTL][clkdiv_pkg::S1_START_BIT];
    st_bypass[clkdiv_pkg::STG_A1] = cfg[clkdiv_pkg::SLOT_A_CTL][clkdiv_pkg::S1_BYPASS_BIT];
    st_nosync[clkdiv_pkg::STG_A1] = cfg[clkdiv_pkg::SLOT_A_CTL][clkdiv_pkg::LS_NOSYNC_BIT];
    // Channel A stage two.
    st_low[clkdiv_pkg::STG_A2]    = cfg[clkdiv_pkg::SLOT_A2_CYC][7:4];
    st_high[clkdiv_pkg::STG_A2]   = cfg[clkdiv_pkg::SLOT_A2_CYC][3:0];
    st_phase[clkdiv_pkg::STG_A2]  = cfg[clkdiv_pkg::SLOT_A_PHS][7:4];
    st_start[clkdiv_pkg::STG_A2]  = cfg[clkdiv_pkg::SLOT_A_CTL][clkdiv_pkg::S2_START_BIT];
    st_bypass[clkdiv_pkg::STG_A2] = cfg[clkdiv_pkg::SLOT_A_CTL][clkdiv_pkg::S2_BYPASS_BIT];
    st_nosync[clkdiv_pkg::STG_A2] = cfg[clkdiv_pkg::SLOT_A_CTL][clkdiv_pkg::LS_NOSYNC_BIT];
    // Channel B stage one.
    st_low[clkdiv_pkg::STG_B1]    = cfg[clkdiv_pkg::SLOT_B1_CYC][7:4];
    st_high[clkdiv_pkg::STG_B1]   = cfg[clkdiv_pkg::SLOT_B1_CYC][3:0];
    st_phase[clkdiv_pkg::STG_B1]  = 4'h0;
    st_start[clkdiv_pkg::STG_B1]  = 1'b0;
    st_bypass[clkdiv_pkg::STG_B1] = 1'b0;
    st_nosync[clkdiv_pkg::STG_B1] = 1'b0;
    hs_force  = cfg[clkdiv_pkg::SLOT_HS_CTL][clkdiv_pkg::HS_FORCE_BIT];
    ls_force  = cfg[clkdiv_pkg::SLOT_A_CTL][clkdiv_pkg::LS_FORCE_BIT];
    hs_direct = cfg[clkdiv_pkg::SLOT_HS_RTE][clkdiv_pkg::DIRECT_BIT];
    dist_clk  = (dist_src_sel == clkdiv_pkg::SRC_OSC) ? osc_clk : ext_clk;
  end

  // ---------------------------------------------------------------------------
  // Divider stages
  // ---------------------------------------------------------------------------
  clkdiv_pkg::div_s st      [0:3];
  clkdiv_pkg::div_s next_st [0:3];
  logic             prev_in [0:3];
  logic             out_lvl [0:3];
  logic             next_out_lvl [0:3];
  logic             in_lvl  [0:3];
  logic             in_rise [0:3];
  logic             sync_on [0:3];

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      in_lvl[i] = dist_clk;
    end
    in_lvl[clkdiv_pkg::STG_A2] = out_lvl[clkdiv_pkg::STG_A1];
    for (int i = 0; i < 4; i++) begin
      in_rise[i] = in_lvl[i] && !prev_in[i];
      sync_on[i] = sync_hold && !st_nosync[i];
      next_st[i] = st[i];
      if (sync_on[i] || st_bypass[i]) begin
        next_st[i] = '{lvl: st_start[i], cnt: 4'h0, hold: st_phase[i]};
      end else if (in_rise[i]) begin
        next_st[i] = div_step(st[i], st_low[i], st_high[i]);
      end
      next_out_lvl[i] = st_bypass[i] ? in_lvl[i] : next_st[i].lvl;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        st[i]      <= '{lvl: 1'b0, cnt: 4'h0, hold: 4'h0};
        prev_in[i] <= 1'b0;
        out_lvl[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        st[i]      <= next_st[i];
        prev_in[i] <= in_lvl[i];
        out_lvl[i] <= next_out_lvl[i];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Output routing
  // ---------------------------------------------------------------------------
  logic hs_sel;
  logic ls_a_sel;

  always_comb begin
    hs_sel = out_lvl[clkdiv_pkg::STG_HS];
    if (hs_direct && dist_src_sel == clkdiv_pkg::SRC_OSC) begin
      hs_sel = osc_clk;
    end else if (hs_direct && dist_src_sel == clkdiv_pkg::SRC_EXT) begin
      hs_sel = ext_clk;
    end else if (sync_hold && st_nosync[clkdiv_pkg::STG_HS]) begin
      hs_sel = hs_force;
    end
    ls_a_sel = out_lvl[clkdiv_pkg::STG_A2];
    if (sync_hold && st_nosync[clkdiv_pkg::STG_A2]) begin
      ls_a_sel = ls_force;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hs_pair_b_out_first  <= 1'b0;
      hs_pair_b_out_second <= 1'b0;
      ls_a_out             <= 1'b0;
      ls_b_stage1_out      <= 1'b0;
      hs_b_dcc_on          <= 1'b1;
      ls_a_dcc_on          <= 1'b1;
    end else begin
      hs_pair_b_out_first  <= hs_sel;
      hs_pair_b_out_second <= hs_sel;
      ls_a_out             <= ls_a_sel;
      ls_b_stage1_out      <= out_lvl[clkdiv_pkg::STG_B1];
      hs_b_dcc_on          <= !cfg[clkdiv_pkg::SLOT_HS_RTE][clkdiv_pkg::DCC_OFF_BIT];
      ls_a_dcc_on          <= !cfg[clkdiv_pkg::SLOT_A_DCC][clkdiv_pkg::DCC_OFF_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_hs_start_level: assert property (@(posedge sys_clk) disable iff (reset)
    (sync_on[0] && !st_bypass[0]) |=> (st[0].lvl == $past(st_start[0])))
    else $error("High-speed divider did not load its start level.");

  a_hs_phase_load: assert property (@(posedge sys_clk) disable iff (reset)
    sync_on[0] |=> (st[0].hold == $past(st_phase[0]) && st[0].cnt == 4'h0))
    else $error("High-speed divider did not load its phase offset.");

  a_hs_divider_route: assert property (@(posedge sys_clk) disable iff (reset)
    (!hs_direct && !sync_hold) |=> (hs_pair_b_out_first == $past(out_lvl[0])))
    else $error("Pair B not driven from its divider.");

  a_hs_osc_route: assert property (@(posedge sys_clk) disable iff (reset)
    (hs_direct && dist_src_sel == 2'b10) |=> (hs_pair_b_out_second == $past(osc_clk)))
    else $error("Oscillator not routed to pair B.");

  a_hs_ext_route: assert property (@(posedge sys_clk) disable iff (reset)
    (hs_direct && dist_src_sel == 2'b00) |=> (hs_pair_b_out_first == $past(ext_clk)))
    else $error("External clock not routed to pair B.");

  a_hs_direct_ignored: assert property (@(posedge sys_clk) disable iff (reset)
    (hs_direct && dist_src_sel == 2'b01 && !sync_hold)
      |=> (hs_pair_b_out_first == $past(out_lvl[0])))
    else $error("Direct bit acted with source 01b.");

  a_dcc_follows_bit: assert property (@(posedge sys_clk) disable iff (reset)
    ##1 (ls_a_dcc_on == !$past(cfg[7][0]) && hs_b_dcc_on == !$past(cfg[2][0])))
    else $error("Duty correction enable does not follow its bit.");

  a_a1_low_count: assert property (@(posedge sys_clk) disable iff (reset)
    (in_rise[1] && !sync_on[1] && !st_bypass[1] && st[1].hold == 4'h0 && !st[1].lvl)
      |=> (st[1].lvl == ($past(st[1].cnt) == $past(st_low[1]))))
    else $error("Stage one low time is wrong.");

  a_a1_high_count: assert property (@(posedge sys_clk) disable iff (reset)
    (in_rise[1] && !sync_on[1] && !st_bypass[1] && st[1].hold == 4'h0 && st[1].lvl)
      |=> (st[1].lvl == ($past(st[1].cnt) != $past(st_high[1]))))
    else $error("Stage one high time is wrong.");

  a_a2_bypass_pass: assert property (@(posedge sys_clk) disable iff (reset)
    st_bypass[2] |=> (out_lvl[2] == $past(out_lvl[1])))
    else $error("Bypassed stage two does not pass its input.");

  a_sync_ignored: assert property (@(posedge sys_clk) disable iff (reset)
    (sync_hold && st_nosync[1] && !in_rise[1] && !st_bypass[1]) |=> $stable(st[1]))
    else $error("Sync acted on a channel that ignores it.");

  a_ls_force_level: assert property (@(posedge sys_clk) disable iff (reset)
    (sync_hold && st_nosync[2]) |=> (ls_a_out == $past(ls_force)))
    else $error("Forced level not driven on channel A.");

  a_b1_low_count: assert property (@(posedge sys_clk) disable iff (reset)
    (in_rise[3] && !sync_hold && st[3].hold == 4'h0 && !st[3].lvl && st[3].cnt != st_low[3])
      |=> !st[3].lvl)
    else $error("Channel B stage one left low too early.");

endmodule
`default_nettype wire

// ---- pkg/clkdiv_pkg.sv ----
// Constants, field layouts and types shared by the output channel divider block.
package clkdiv_pkg;

  // ---------------------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam logic [8:0] IDX_HS_DIV_B_CYCLES     = 9'h196;
  localparam logic [8:0] IDX_HS_DIV_B_SYNC_PHASE = 9'h197;
  localparam logic [8:0] IDX_HS_DIV_B_ROUTING    = 9'h198;
  localparam logic [8:0] IDX_LS_A_STAGE1_CYCLES  = 9'h199;
  localparam logic [8:0] IDX_LS_A_PHASE_OFFSETS  = 9'h19a;
  localparam logic [8:0] IDX_LS_A_STAGE2_CYCLES  = 9'h19b;
  localparam logic [8:0] IDX_LS_A_CONTROL        = 9'h19c;
  localparam logic [8:0] IDX_LS_A_DUTY_CORR      = 9'h19d;
  localparam logic [8:0] IDX_LS_B_STAGE1_CYCLES  = 9'h19e;
  localparam logic [3:0] SLOT_COUNT              = 4'h9;
  localparam int unsigned ADDR_W                 = 11;

  // ---------------------------------------------------------------------------
  // Slots of the register array, counted from the first index
  // ---------------------------------------------------------------------------
  localparam logic [3:0] SLOT_HS_CYC = 4'h0;
  localparam logic [3:0] SLOT_HS_CTL = 4'h1;
  localparam logic [3:0] SLOT_HS_RTE = 4'h2;
  localparam logic [3:0] SLOT_A1_CYC = 4'h3;
  localparam logic [3:0] SLOT_A_PHS  = 4'h4;
  localparam logic [3:0] SLOT_A2_CYC = 4'h5;
  localparam logic [3:0] SLOT_A_CTL  = 4'h6;
  localparam logic [3:0] SLOT_A_DCC  = 4'h7;
  localparam logic [3:0] SLOT_B1_CYC = 4'h8;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned HS_BYPASS_BIT  = 7;
  localparam int unsigned HS_NOSYNC_BIT  = 6;
  localparam int unsigned HS_FORCE_BIT   = 5;
  localparam int unsigned HS_START_BIT   = 4;
  localparam int unsigned DIRECT_BIT     = 1;
  localparam int unsigned DCC_OFF_BIT    = 0;
  localparam int unsigned S2_BYPASS_BIT  = 5;
  localparam int unsigned S1_BYPASS_BIT  = 4;
  localparam int unsigned LS_NOSYNC_BIT  = 3;
  localparam int unsigned LS_FORCE_BIT   = 2;
  localparam int unsigned S2_START_BIT   = 1;
  localparam int unsigned S1_START_BIT   = 0;

  // ---------------------------------------------------------------------------
  // Reset values and writable masks
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] MASK_FULL   = 8'hff;
  localparam logic [7:0] MASK_ROUTE  = 8'h03;
  localparam logic [7:0] MASK_LS_CTL = 8'h3f;
  localparam logic [7:0] MASK_DCC    = 8'h01;

  // ---------------------------------------------------------------------------
  // Distribution source select codes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SRC_EXT   = 2'b00;
  localparam logic [1:0] SRC_OTHER = 2'b01;
  localparam logic [1:0] SRC_OSC   = 2'b10;

  // ---------------------------------------------------------------------------
  // Divider stages and types
  // ---------------------------------------------------------------------------
  localparam int unsigned STAGES  = 4;
  localparam int unsigned STG_HS  = 0;
  localparam int unsigned STG_A1  = 1;
  localparam int unsigned STG_A2  = 2;
  localparam int unsigned STG_B1  = 3;

  typedef struct packed {
    logic       lvl;
    logic [3:0] cnt;
    logic [3:0] hold;
  } div_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_e;

endpackage

// ---- verification/tb.sv ----
// Self-checking testbench for the output channel divider block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ---------------------------------------------------------------------------
  // Row types, stimulus and observed signals
  // ---------------------------------------------------------------------------
  typedef struct packed {logic [8:0] idx; logic [7:0] wd; logic [7:0] rd;} reg_row_s;
  typedef struct packed {
    logic [8:0] idx;
    logic [7:0] val;
    logic [7:0] ctl;
    logic [1:0] sel;
    logic [7:0] hi;
    logic [7:0] lo;
  } div_row_s;

  logic        sys_clk        = 1'b0;
  logic        reset          = 1'b1;
  logic [10:0] avs_address    = 11'h000;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        osc_clk        = 1'b0;
  logic        ext_clk        = 1'b0;
  logic [1:0]  dist_src_sel   = 2'b10;
  logic        sync_hold      = 1'b0;
  logic [1:0]  ecnt           = 2'b00;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        hs_pair_b_out_first;
  logic        hs_pair_b_out_second;
  logic        ls_a_out;
  logic        ls_b_stage1_out;
  logic        hs_b_dcc_on;
  logic        ls_a_dcc_on;
  logic [31:0] q;
  int          fails          = 0;
  int          n_compared     = 0;
  int          cycles         = 0;
  int          hi;
  int          lo;
  int          d0;
  int          d1;

  reg_row_s reg_rows [11] = '{'{9'h196, 8'h5a, 8'h5a}, '{9'h197, 8'ha5, 8'ha5},
    '{9'h198, 8'hff, 8'h03}, '{9'h199, 8'h3c, 8'h3c}, '{9'h19a, 8'hc3, 8'hc3},
    '{9'h19b, 8'h69, 8'h69}, '{9'h19c, 8'hff, 8'h3f}, '{9'h19d, 8'hff, 8'h01},
    '{9'h19e, 8'h96, 8'h96}, '{9'h1a0, 8'hff, 8'h00}, '{9'h000, 8'h11, 8'h00}};
  div_row_s div_rows [5] = '{'{9'h19e, 8'h21, 8'h00, 2'd2, 8'h04, 8'h06},
    '{9'h199, 8'h12, 8'h20, 2'd1, 8'h06, 8'h04}, '{9'h19b, 8'h10, 8'h10, 2'd1, 8'h02, 8'h04},
    '{9'h199, 8'h00, 8'h00, 2'd1, 8'h04, 8'h08}, '{9'h196, 8'h01, 8'h00, 2'd0, 8'h04, 8'h02}};
  div_row_s phs_rows [3] = '{'{9'h197, 8'h03, 8'h00, 2'd0, 8'h06, 8'h00},
    '{9'h19a, 8'h03, 8'h20, 2'd1, 8'h06, 8'h00}, '{9'h19a, 8'h30, 8'h10, 2'd1, 8'h06, 8'h00}};
  div_row_s lvl_rows [8] = '{'{9'h197, 8'h10, 8'h00, 2'd0, 8'h01, 8'h00},
    '{9'h197, 8'h00, 8'h00, 2'd0, 8'h00, 8'h00}, '{9'h19c, 8'h02, 8'h02, 2'd1, 8'h01, 8'h00},
    '{9'h19c, 8'h21, 8'h21, 2'd1, 8'h01, 8'h00}, '{9'h19c, 8'h00, 8'h00, 2'd1, 8'h00, 8'h00},
    '{9'h19c, 8'h0c, 8'h0c, 2'd1, 8'h01, 8'h00}, '{9'h19c, 8'h08, 8'h08, 2'd1, 8'h00, 8'h00},
    '{9'h19c, 8'h04, 8'h04, 2'd1, 8'h00, 8'h00}};

  clock_divider_channels i_clock_divider_channels (
    .sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .osc_clk(osc_clk),
    .ext_clk(ext_clk), .dist_src_sel(dist_src_sel), .sync_hold(sync_hold),
    .hs_pair_b_out_first(hs_pair_b_out_first), .hs_pair_b_out_second(hs_pair_b_out_second),
    .ls_a_out(ls_a_out), .ls_b_stage1_out(ls_b_stage1_out), .hs_b_dcc_on(hs_b_dcc_on),
    .ls_a_dcc_on(ls_a_dcc_on));

  // ---------------------------------------------------------------------------
  // Clocks, source clocks and timeout
  // ---------------------------------------------------------------------------
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    osc_clk <= ~osc_clk;
    ecnt <= ecnt + 2'd1;
    ext_clk <= ecnt[1];
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  function automatic logic pick(input logic [1:0] s);
    case (s)
      2'd0: pick = hs_pair_b_out_first;
      2'd1: pick = ls_a_out;
      default: pick = ls_b_stage1_out;
    endcase
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      fails++;
    end
  endtask

  task automatic bus(input logic wr, input logic [8:0] idx, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic setup(input div_row_s r, input logic [7:0] v);
    bus(1'b1, 9'h19c, r.ctl, 4'hf);
    bus(1'b1, r.idx, v, 4'hf);
  endtask

  task automatic expect_runs(input logic [1:0] s, input int h, input int l);
    int g;
    g = 0;
    repeat (2) begin
      while (pick(s) !== 1'b0 && g < 400) @(negedge sys_clk) g++;
      while (pick(s) !== 1'b1 && g < 400) @(negedge sys_clk) g++;
    end
    hi = 0;
    lo = 0;
    while (pick(s) === 1'b1 && hi < 400) @(negedge sys_clk) hi++;
    while (pick(s) === 1'b0 && lo < 400) @(negedge sys_clk) lo++;
    check("high run", 32'(hi), 32'(h));
    check("low run", 32'(lo), 32'(l));
  endtask

  task automatic phase_delay(input div_row_s r, input logic [7:0] v, output int d);
    setup(r, v);
    @(posedge sys_clk) sync_hold <= 1'b1;
    repeat (8) @(posedge sys_clk);
    while (osc_clk !== 1'b1) @(posedge sys_clk);
    sync_hold <= 1'b0;
    d = 0;
    while (pick(r.sel) !== 1'b1 && d < 200) @(negedge sys_clk) d++;
  endtask

  task automatic conclude();
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (reg_rows[i]) begin
      bus(1'b1, reg_rows[i].idx, reg_rows[i].wd, 4'hf);
      bus(1'b0, reg_rows[i].idx, 8'h00, 4'hf);
      check("readback", q, 32'(reg_rows[i].rd));
    end
    @(negedge sys_clk);
    check("hs dcc on", 32'(hs_b_dcc_on), 32'h0000_0000);
    check("ls dcc on", 32'(ls_a_dcc_on), 32'h0000_0000);
    bus(1'b1, 9'h199, 8'hff, 4'he);
    bus(1'b0, 9'h199, 8'h00, 4'hf);
    check("masked write", q, 32'h0000_003c);
    @(posedge sys_clk) reset <= 1'b1;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    check("reset wait", 32'(avs_waitrequest), 32'h0000_0001);
    check("reset hs dcc", 32'(hs_b_dcc_on), 32'h0000_0001);
    check("reset ls dcc", 32'(ls_a_dcc_on), 32'h0000_0001);
    @(posedge sys_clk) reset <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, 9'h196 + 9'(i), 8'h00, 4'hf);
      check("reset value", q, 32'h0000_0000);
    end
    foreach (div_rows[i]) begin
      setup(div_rows[i], div_rows[i].val);
      expect_runs(div_rows[i].sel, div_rows[i].hi, div_rows[i].lo);
    end
    foreach (phs_rows[i]) begin
      phase_delay(phs_rows[i], 8'h00, d0);
      phase_delay(phs_rows[i], phs_rows[i].val, d1);
      check("phase shift", 32'(d1 - d0), 32'(phs_rows[i].hi));
    end
    foreach (lvl_rows[i]) begin
      setup(lvl_rows[i], lvl_rows[i].val);
      @(posedge sys_clk) sync_hold <= 1'b1;
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      check("held level", 32'(pick(lvl_rows[i].sel)), 32'(lvl_rows[i].hi[0]));
      @(posedge sys_clk) sync_hold <= 1'b0;
    end
    bus(1'b1, 9'h198, 8'h02, 4'hf);
    expect_runs(2'd0, 1, 1);
    check("pair second", 32'(hs_pair_b_out_second), 32'h0000_0001);
    @(posedge sys_clk) dist_src_sel <= 2'b00;
    expect_runs(2'd0, 2, 2);
    @(posedge sys_clk) dist_src_sel <= 2'b01;
    expect_runs(2'd0, 8, 4);
    conclude();
  end
endmodule
`default_nettype wire
